// >>> core/oadc_pkg.sv
/*
 * Shared constants and carrier types for the octal converter output path.
 * Assumes a single 20 MHz system clock; the sample clock arrives from outside.
 */
package oadc_pkg;
    localparam int          NUM_CHANNELS   = 8;
    localparam int          RESULT_BITS    = 10;
    localparam int          PAD_BITS       = 2;
    localparam int          WORD_BITS      = RESULT_BITS + PAD_BITS;
    localparam int          SERIAL_MULT    = 12;   // Serializer clock per sample clock
    localparam int          BIT_CLOCK_MULT = 6;    // Bit clock per sample clock
    localparam int          LATENCY_WHOLE  = 6;    // Whole sample periods of pipeline delay
    localparam int          PIPE_STAGES    = LATENCY_WHOLE + 1;
    localparam int          FIFO_DEPTH     = 4;
    localparam int          PERIOD_BITS    = 16;
    localparam int          MIN_PERIOD_CYC = 2 * SERIAL_MULT; // Fastest tick spacing is 2
    localparam logic [1:0]  PAD_VALUE      = 2'h0;
    localparam logic [15:0] PERIOD_RESET   = 16'h0000;

    typedef logic [RESULT_BITS-1:0] code_t;

    // One conversion result per channel, taken on the same sample edge
    typedef struct packed {
        code_t [NUM_CHANNELS-1:0] code;
    } sample_set_t;

    // Serializer phase along one word
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_SHIFT = 2'b01,
        SER_HOLD  = 2'b11
    } ser_state_t;
endpackage : oadc_pkg

// >>> core/oadc_word_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on clk; storage is flip-flops.
 */
`timescale 1ns/1ns
module oadc_word_fifo #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    wire              doWrite = inValid && inReady;
    wire              doRead  = outValid && outReady;

    // Full and empty come straight from the occupancy count
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = store[rdPtr];

    // Pointers wrap at DEPTH so non-power-of-two depths also work
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWrite) begin
                store[wrPtr] <= inData;
                wrPtr        <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule : oadc_word_fifo

// >>> core/octal_adc_serial_lvds_output.sv
/*
 * Digital output path of an eight-channel 10-bit converter: shared sample
 * edge, 6.5-period pipeline, word buffer, and a 12x serializer that drives
 * eight data pairs plus a 6x bit clock and a 1x word clock.
 * Assumes clk is far faster than the sample clock (at least 24 clk per period)
 * and that the converter core presents signed results on clk.
 */
// Functional notes
// - All eight channels capture their results on the same sample clock edge.
// - A 12x serializer rate is derived internally by locking to the sample clock period.
// - Each channel's result leaves on its own differential output pair.
// - Each serial word is 12 bits, ten result bits plus two pads, sent LSB first.
// - Both output clocks come from the same serializer ticks as the data bits.
// - A sample reaches the output 7 sample periods after its capture edge (buffered at 6.5, sent from the next rise).
// - Minus full scale maps to code zero and plus full scale to all ones, straight binary.
`timescale 1ns/1ns
module octal_adc_serial_lvds_output #(
    parameter int CHANNELS = oadc_pkg::NUM_CHANNELS,
    parameter int DEPTH    = oadc_pkg::FIFO_DEPTH
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 sample_clock_in,
    input  wire oadc_pkg::sample_set_t coreResult,
    output logic [CHANNELS-1:0]       serialDataP,
    output logic [CHANNELS-1:0]       serialDataN,
    output logic                      bitClockP,
    output logic                      bitClockN,
    output logic                      wordClockP,
    output logic                      wordClockN,
    output logic                      pllLocked,
    output logic                      wordDropped
);
    localparam int PB = oadc_pkg::PERIOD_BITS;

    // Straight binary from two's complement: flip the sign bit
    function automatic oadc_pkg::code_t toBinary(input oadc_pkg::code_t s);
        toBinary = {~s[oadc_pkg::RESULT_BITS-1], s[oadc_pkg::RESULT_BITS-2:0]};
    endfunction : toBinary

    // Pad below the result so the zero pads leave first
    function automatic logic [oadc_pkg::WORD_BITS-1:0] padWord(input oadc_pkg::code_t c);
        padWord = {c, oadc_pkg::PAD_VALUE};
    endfunction : padWord

    // Input synchroniser; syncB and syncC feed the edge logic
    logic syncA;
    logic syncB;
    logic syncC;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
            syncC <= 1'b0;
        end else begin
            syncA <= sample_clock_in;
            syncB <= syncA;
            syncC <= syncB;
        end
    end
    wire sampleRise = syncB && !syncC;
    wire sampleFall = !syncB && syncC;

    // Pipeline: captured on a rise, released on the fall 6.5 periods later
    oadc_pkg::sample_set_t pipe [oadc_pkg::PIPE_STAGES];
    logic [oadc_pkg::PIPE_STAGES-1:0] pipeValid;
    oadc_pkg::sample_set_t capturedSet;
    logic fifoInReady;
    logic [PB-1:0] periodLen;
    wire           lockNow = (periodLen >= PB'(oadc_pkg::MIN_PERIOD_CYC));
    // Pushes wait for lock: words buffered while unlocked would add to the latency
    wire  pushWord = sampleFall && pipeValid[oadc_pkg::PIPE_STAGES-1] && lockNow;

    // One shared capture for all channels, converted to straight binary
    always_comb begin
        capturedSet = coreResult;
        for (int c = 0; c < oadc_pkg::NUM_CHANNELS; c++) begin
            capturedSet.code[c] = toBinary(coreResult.code[c]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pipeValid <= '0;
        end else if (sampleRise) begin
            pipe[0]   <= capturedSet;
            pipeValid <= {pipeValid[oadc_pkg::PIPE_STAGES-2:0], 1'b1};
            for (int s = 1; s < oadc_pkg::PIPE_STAGES; s++) begin
                pipe[s] <= pipe[s-1];
            end
        end
    end

    // Word buffer; a full buffer refuses the push and the loss is flagged
    oadc_pkg::sample_set_t fifoOut;
    logic                  fifoOutValid;
    logic                  popWord;
    oadc_word_fifo #(
        .WIDTH ($bits(oadc_pkg::sample_set_t)),
        .DEPTH (DEPTH)
    ) wordBuffer (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inData   (pipe[oadc_pkg::PIPE_STAGES-1]),
        .inValid  (pushWord),
        .inReady  (fifoInReady),
        .outData  (fifoOut),
        .outValid (fifoOutValid),
        .outReady (popWord)
    );

    // Period tracker stands in for the multiplying loop
    logic [PB-1:0] periodCount;
    logic [PB-1:0] phaseAcc;
    wire  [PB-1:0] accStep = phaseAcc + PB'(oadc_pkg::SERIAL_MULT);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            periodCount <= oadc_pkg::PERIOD_RESET;
            periodLen   <= oadc_pkg::PERIOD_RESET;
        end else if (sampleRise) begin
            periodCount <= PB'(1);
            periodLen   <= periodCount;
        end else if (periodCount != '1) begin
            periodCount <= periodCount + 1'b1;
        end
    end

    // Twelve evenly spread ticks per period, re-phased on each rise
    oadc_pkg::ser_state_t serState;
    oadc_pkg::ser_state_t next_serState;
    logic [3:0]           bitIdx;
    wire                  midTick = (serState == oadc_pkg::SER_SHIFT) && (accStep >= periodLen)
                                    && (bitIdx != 4'(oadc_pkg::WORD_BITS-1));
    wire                  startTick = sampleRise && lockNow;
    wire                  serTick = startTick || midTick;
    wire [3:0]            next_bitIdx = startTick ? 4'h0 : bitIdx + 4'h1;
    assign popWord = startTick && fifoOutValid;

    always_comb begin
        case (serState)
            oadc_pkg::SER_IDLE:  next_serState = startTick ? oadc_pkg::SER_SHIFT : serState;
            oadc_pkg::SER_SHIFT: next_serState = startTick ? oadc_pkg::SER_SHIFT :
                                 (midTick && next_bitIdx == 4'(oadc_pkg::WORD_BITS-1)) ?
                                 oadc_pkg::SER_HOLD : serState;
            oadc_pkg::SER_HOLD:  next_serState = startTick ? oadc_pkg::SER_SHIFT : serState;
            default:             next_serState = oadc_pkg::SER_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serState <= oadc_pkg::SER_IDLE;
            bitIdx   <= 4'h0;
            phaseAcc <= '0;
        end else begin
            serState <= lockNow ? next_serState : oadc_pkg::SER_IDLE;
            if (serTick) begin
                bitIdx <= next_bitIdx;
            end
            // Fractional spacing: carry P out of the accumulator on each mid-word tick; the start tick reloads it
            phaseAcc <= startTick ? PB'(oadc_pkg::SERIAL_MULT) :
                        midTick ? accStep - periodLen : accStep;
        end
    end

    // Word held for the whole frame; an empty buffer repeats the last word
    logic [CHANNELS-1:0][oadc_pkg::WORD_BITS-1:0] frameWord;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frameWord <= '0;
        end else if (popWord) begin
            for (int c = 0; c < CHANNELS; c++) begin
                frameWord[c] <= padWord(fifoOut.code[c]);
            end
        end
    end
    wire [CHANNELS-1:0][oadc_pkg::WORD_BITS-1:0] shiftSrc = popWord ?
        {CHANNELS{oadc_pkg::WORD_BITS'(0)}} | frameLoad() : frameWord;

    function automatic logic [CHANNELS-1:0][oadc_pkg::WORD_BITS-1:0] frameLoad();
        for (int c = 0; c < CHANNELS; c++) begin
            frameLoad[c] = padWord(fifoOut.code[c]);
        end
    endfunction : frameLoad

    // Data and both clocks change on the same tick, so they stay aligned
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serialDataP <= '0;
            serialDataN <= '1;
            bitClockP   <= 1'b0;
            bitClockN   <= 1'b1;
            wordClockP  <= 1'b0;
            wordClockN  <= 1'b1;
        end else if (serTick) begin
            for (int c = 0; c < CHANNELS; c++) begin
                serialDataP[c] <= shiftSrc[c][next_bitIdx];
                serialDataN[c] <= ~shiftSrc[c][next_bitIdx];
            end
            bitClockP  <= ~next_bitIdx[0];
            bitClockN  <= next_bitIdx[0];
            wordClockP <= (next_bitIdx < 4'(oadc_pkg::WORD_BITS/2));
            wordClockN <= !(next_bitIdx < 4'(oadc_pkg::WORD_BITS/2));
        end
    end

    // Status flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pllLocked   <= 1'b0;
            wordDropped <= 1'b0;
        end else begin
            pllLocked   <= lockNow;
            wordDropped <= pushWord && !fifoInReady;
        end
    end

    // Checks
    AST_PAD_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
        popWord |=> (serialDataP == '0))
        else $error("pad bit not zero at word start");
    AST_WORD_HIGH_AT_START: assert property (@(posedge clk) disable iff (sys_rst)
        startTick |=> (wordClockP && bitClockP && bitIdx == 4'h0))
        else $error("word clock not high at word start");
    AST_BIT_CLK_TOGGLES: assert property (@(posedge clk) disable iff (sys_rst)
        midTick |=> (bitClockP != $past(bitClockP)))
        else $error("bit clock did not toggle with data");
    AST_WORD_LOW_SECOND_HALF: assert property (@(posedge clk) disable iff (sys_rst)
        (serTick && next_bitIdx == 4'h6) |=> !wordClockP)
        else $error("word clock not low in second half");
    AST_LSB_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
        (midTick && next_bitIdx == 4'h2) |=> (serialDataP[0] == frameWord[0][2]))
        else $error("first result bit is not the LSB");
    AST_LATENCY: assert property (@(posedge clk) disable iff (sys_rst)
        pushWord |-> pipeValid[oadc_pkg::PIPE_STAGES-1] && sampleFall)
        else $error("push outside the half-period release point");
    AST_SHARED_EDGE: assert property (@(posedge clk) disable iff (sys_rst)
        sampleRise |=> (pipe[0].code[1] == toBinary($past(coreResult.code[1]))))
        else $error("channel not captured on shared edge");
    AST_DIFF_PAIR: assert property (@(posedge clk) disable iff (sys_rst)
        (serialDataN == ~serialDataP) && (bitClockN == !bitClockP))
        else $error("differential pair out of step");
    AST_LOCK_GATES: assert property (@(posedge clk) disable iff (sys_rst)
        !lockNow |=> (serState == oadc_pkg::SER_IDLE))
        else $error("serializer runs without lock");

    COV_LOCK: cover property (@(posedge clk) disable iff (sys_rst) $rose(pllLocked));
    COV_POP: cover property (@(posedge clk) disable iff (sys_rst) popWord);
    COV_FULL_WORD: cover property (@(posedge clk) disable iff (sys_rst)
        serState == oadc_pkg::SER_HOLD);
    COV_DROP: cover property (@(posedge clk) disable iff (sys_rst) wordDropped);
endmodule : octal_adc_serial_lvds_output

// >>> verification/oadc_rx_model.sv
/*
 * Deserializing receiver standing at the far end of the serial pairs.
 * Assumes clk is fast enough to see every bit clock edge.
 */
`timescale 1ns/1ns
module oadc_rx_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] serialDataP,
    input  wire logic [7:0] serialDataN,
    input  wire logic       bitClockP,
    input  wire logic       bitClockN,
    input  wire logic       wordClockP,
    input  wire logic       wordClockN,
    output logic [7:0][11:0] rxWord,
    output logic            rxStrobe,
    output logic [3:0]      frameSlots,
    output logic [3:0]      frameHigh,
    output logic            pairErr
);
    logic [7:0][11:0] shiftW;
    logic             prevBit;
    logic             prevWord;
    logic [3:0]       cnt;
    logic [3:0]       hiCnt;
    logic [3:0]       idx;
    logic             start;

    // Each bit clock edge opens a slot; a word clock rise opens a frame
    always @(posedge clk) begin
        start = wordClockP && !prevWord;
        idx = start ? 4'h0 : cnt;
        rxStrobe <= 1'b0;
        if (sys_rst) begin
            prevBit  <= 1'b0;
            prevWord <= 1'b0;
            cnt      <= 4'h0;
            hiCnt    <= 4'h0;
            pairErr  <= 1'b0;
        end else begin
            prevBit  <= bitClockP;
            prevWord <= wordClockP;
            if (serialDataN !== ~serialDataP || bitClockN !== ~bitClockP
                || wordClockN !== ~wordClockP) begin
                pairErr <= 1'b1;
            end
            if (bitClockP != prevBit) begin
                if (start) begin // Previous frame is complete here
                    rxWord     <= shiftW;
                    rxStrobe   <= 1'b1;
                    frameSlots <= cnt;
                    frameHigh  <= hiCnt;
                end
                for (int c = 0; c < 8; c++) begin
                    if (idx < 4'hc) shiftW[c][idx] <= serialDataP[c];
                end
                cnt   <= idx + 4'h1;
                hiCnt <= (start ? 4'h0 : hiCnt) + {3'h0, wordClockP};
            end
        end
    end
endmodule : oadc_rx_model

// >>> verification/octal_adc_serial_lvds_output_bench.sv
/*
 * Self-checking bench: reset, refused fast clock, frame content, latency, buffer.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ns
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module octal_adc_serial_lvds_output_bench;
    logic clk, sys_rst, sampleClk, dropSeen;
    oadc_pkg::sample_set_t coreResult;
    logic [7:0] dP, dN;
    logic bP, bN, wP, wN, pllLocked, wordDropped, rxStrobe, pairErr;
    logic [7:0][11:0] rxWord;
    logic [3:0] frameSlots, frameHigh;
    int errors, cmp_count, halfNs;
    oadc_pkg::code_t valA [8] = '{10'h200, 10'h1ff, 10'h000, 10'h3ff,
                                   10'h001, 10'h300, 10'h0ff, 10'h064};

    octal_adc_serial_lvds_output dut_u (.clk(clk), .sys_rst(sys_rst),
        .sample_clock_in(sampleClk), .coreResult(coreResult), .serialDataP(dP),
        .serialDataN(dN), .bitClockP(bP), .bitClockN(bN), .wordClockP(wP),
        .wordClockN(wN), .pllLocked(pllLocked), .wordDropped(wordDropped));
    oadc_rx_model rx_u (.clk(clk), .sys_rst(sys_rst), .serialDataP(dP),
        .serialDataN(dN), .bitClockP(bP), .bitClockN(bN), .wordClockP(wP),
        .wordClockN(wN), .rxWord(rxWord), .rxStrobe(rxStrobe),
        .frameSlots(frameSlots), .frameHigh(frameHigh), .pairErr(pairErr));

    // Clocks; the sample clock is offset by 13 so its edges never fall on a clk edge
    initial begin clk = 0; forever #25 clk = ~clk; end
    initial begin sampleClk = 0; #13; forever #(halfNs) sampleClk = ~sampleClk; end
    always @(posedge clk) if (wordDropped === 1'b1) dropSeen <= 1'b1;

    // Straight binary is the sign-inverted code, pads in the two lowest slots
    function automatic logic [11:0] exp_word(input oadc_pkg::code_t v);
        return {~v[9], v[8:0], 2'h0};
    endfunction : exp_word

    task automatic load(input bit swap);
        for (int c = 0; c < 8; c++) coreResult.code[c] = valA[swap ? 7 - c : c];
    endtask : load

    task automatic wait_strobe;
        int n;
        n = 0;
        do begin @(posedge clk); #2; n++; end while (rxStrobe !== 1'b1 && n < 200);
        `CHECK(rxStrobe, 1'b1)
    endtask : wait_strobe

    task automatic check_all(input bit swap);
        for (int c = 0; c < 8; c++) `CHECK(rxWord[c], exp_word(valA[swap ? 7 - c : c]))
    endtask : check_all

    // Too fast a sample clock: no lock and outputs hold their idle levels
    task automatic check_refused;
        halfNs = 200;
        repeat (40) @(posedge clk);
        #2;
        `CHECK(pllLocked, 1'b0)
        `CHECK({dP, bP, wP}, 10'h000)
    endtask : check_refused

    // Steady slow clock: lock, then whole frames with the right framing
    task automatic check_frames;
        int n;
        halfNs = 1200;
        n = 0;
        while (pllLocked !== 1'b1 && n < 600) begin @(posedge clk); #2; n++; end
        `CHECK(pllLocked, 1'b1)
        repeat (10) wait_strobe();
        check_all(0);
        `CHECK(frameSlots, 4'hc)
        `CHECK(frameHigh, 4'h6)
        `CHECK(pairErr, 1'b0)
    endtask : check_frames

    // New inputs before rise k show first in the frame started at rise k+7
    task automatic check_latency;
        @(negedge sampleClk);
        @(posedge clk);
        #2;
        load(1);
        for (int i = 0; i < 8; i++) begin wait_strobe(); check_all(0); end
        wait_strobe();
        check_all(1);
        `CHECK(dropSeen, 1'b0)
    endtask : check_latency

    // Buffer seen through the top: one push and one pop per period, so no loss
    task automatic check_buffer;
        for (int i = 0; i < 4; i++) begin
            wait_strobe();
            check_all(0);
            `CHECK(dropSeen, 1'b0)
            `CHECK(frameSlots, 4'hc)
        end
        `CHECK(pairErr, 1'b0)
    endtask : check_buffer

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    initial begin #400000; errors++; give_verdict(); end

    initial begin
        sys_rst = 1; halfNs = 200; dropSeen = 0;
        load(0);
        repeat (4) @(posedge clk);
        #2;
        sys_rst = 0;
        `CHECK({dP, dN, bP, bN, wP, wN, pllLocked, wordDropped}, 22'h003fd4)
        check_refused();
        check_frames();
        check_buffer();
        check_latency();
        give_verdict();
    end
endmodule : octal_adc_serial_lvds_output_bench
